//--- core/tmdsrx_pkg.sv
// Shared constants for the three-lane line-code receiver.
// Assumes the oversampling front end delivers forty samples per lane per link clock.
package tmdsrx_pkg;
  // ************************************************************
  // Link geometry
  // ************************************************************
  localparam int LANES = 3;
  localparam int CHAR_W = 10;
  localparam int DATA_W = 8;
  localparam int OSR = 4;
  localparam int SAMPLE_W = CHAR_W * OSR;
  localparam int CAND_W = 6;
  localparam logic [CAND_W-1:0] CAND_MAX = 6'h27;
  localparam int INV_BIT = 9;
  localparam int XOR_BIT = 8;

  // ************************************************************
  // Control characters and their two-bit codes
  // ************************************************************
  localparam logic [CHAR_W-1:0] CTRL_CHAR_00 = 10'h354;
  localparam logic [CHAR_W-1:0] CTRL_CHAR_01 = 10'h0AB;
  localparam logic [CHAR_W-1:0] CTRL_CHAR_10 = 10'h154;
  localparam logic [CHAR_W-1:0] CTRL_CHAR_11 = 10'h2AB;

  // ************************************************************
  // Stream word layout (link to system FIFO)
  // ************************************************************
  localparam int PIX_W = 24;
  localparam int WORD_W = PIX_W + 1;
  localparam int W_DE = 24;
  localparam int RED_LSB = 16;
  localparam int GRN_LSB = 8;
  localparam int BLU_LSB = 0;
  localparam int HS_BIT = 0;
  localparam int VS_BIT = 1;
  localparam int USER1_BIT = 3;
  localparam int USER2_BIT = 4;
  localparam int DECRYPT_EN_BIT = 5;
  localparam int CTRL_PAD_W = 18;
  localparam int FIFO_DEPTH = 4;

  // ************************************************************
  // Alignment and activity defaults
  // ************************************************************
  localparam int LOCK_HITS = 16;
  localparam int UNLOCK_MISSES = 200;
  localparam int TRANS_FOR_ACTIVE = 8;
  localparam int INACTIVE_PIXELS = 1000000;
endpackage

//--- core/tmdsrx_top.sv
// Line-code receiver: per-lane alignment, deskew, decode, FIFO crossing, pixel and sync outputs.
// Assumes a front end sampling each lane at four phases of a 10x clock, forty samples per clk_link_i.
// What this block, its front end and the far end do
// R1 - Every lane carries one ten-bit character per eight-bit value, ten bits per pixel.
// R2 - Each lane is sampled four times per bit from four phases of a 10x clock.
// R3 - Lane skew up to one pixel period is removed before characters are combined.
// R4 - Each lane keeps its own alignment for as long as the link is active.
// R5 - Bit and character boundaries are found on transition-rich control characters in blanking.
// R6 - The far end sends at least 128 pixel periods of blanking control characters.
// R7 - The far end picks one of two characters per pixel for balance and fewest transitions.
// R8 - Active-video flag is high for pixel characters, low for control characters.
// R9 - Active video maps lane 2 to red, lane 1 to green, lane 0 to blue.
// R10 - Blanking maps lane 0 codes to syncs, lanes 1 and 2 to user controls.
// R11 - Only control bits 2 and 1 reach outputs; bits 0 and 3 never appear.
// R12 - Lane 2 control bit 3 enables decryption of incoming pixel data internally.
// R13 - Encrypted pixel data is decrypted before it reaches the pixel outputs.
// R14 - Decryption starts only after protection keys are loaded and decrypted.
// R15 - Every rise and every fall of the active-video flag counts as one transition.
// R16 - Link activity follows the time between active-video flag transitions.
// R17 - One million pixel periods without a transition drive link activity low.
// R18 - Link activity goes high right after the first eight transitions.
// R19 - Pixel characters decode by undoing inversion and XOR or XNOR chaining.
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Dual-clock FIFO with gray-coded pointers
// ************************************************************
module tmdsrx_fifo
  import tmdsrx_pkg::*;
#(
  parameter int WIDTH = WORD_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic wr_clk_i,
  input wire logic wr_rst_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic rd_clk_i,
  input wire logic rd_rst_i,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [WIDTH-1:0] rd_data_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wbin;
    logic [AW:0] wgray;
    logic [AW:0] rg_meta;
    logic [AW:0] rg_sync;
  } tmdsrx_fwr_s;

  typedef struct packed {
    logic [AW:0] rbin;
    logic [AW:0] rgray;
    logic [AW:0] wg_meta;
    logic [AW:0] wg_sync;
  } tmdsrx_frd_s;

  tmdsrx_fwr_s w, next_w;
  tmdsrx_frd_s r, next_r;

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  // Pointers need two address bits for the full test below
  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("tmdsrx_fifo depth must be a power of two of at least four");
  end

  // Full compares against the synchronised read pointer, so it is pessimistic, never optimistic
  assign wr_ready_o = (w.wgray != {~w.rg_sync[AW:AW-1], w.rg_sync[AW-2:0]});
  assign rd_valid_o = (r.rgray != r.wg_sync);
  assign rd_data_o = w.mem[r.rbin[AW-1:0]];

  // Write side
  always_comb
  begin
    next_w = w;
    next_w.rg_meta = r.rgray;
    next_w.rg_sync = w.rg_meta;
    if (wr_valid_i && wr_ready_o)
    begin
      next_w.mem[w.wbin[AW-1:0]] = wr_data_i;
      next_w.wbin = w.wbin + 1'b1;
      next_w.wgray = bin2gray(next_w.wbin);
    end
    if (wr_rst_i)
    begin
      next_w.wbin = '0;
      next_w.wgray = '0;
      next_w.rg_meta = '0;
      next_w.rg_sync = '0;
    end
  end

  // Read side
  always_comb
  begin
    next_r = r;
    next_r.wg_meta = w.wgray;
    next_r.wg_sync = r.wg_meta;
    if (rd_valid_o && rd_ready_i)
    begin
      next_r.rbin = r.rbin + 1'b1;
      next_r.rgray = bin2gray(next_r.rbin);
    end
    if (rd_rst_i)
    begin
      next_r = '0;
    end
  end

  always_ff @(posedge wr_clk_i)
  begin
    w <= next_w;
  end

  always_ff @(posedge rd_clk_i)
  begin
    r <= next_r;
  end
endmodule // tmdsrx_fifo

// ************************************************************
// Receiver top
// ************************************************************
module tmdsrx_top
  import tmdsrx_pkg::*;
#(
  parameter int LOCK_HITS_P = LOCK_HITS,
  parameter int UNLOCK_MISSES_P = UNLOCK_MISSES,
  parameter int INACTIVE_PIXELS_P = INACTIVE_PIXELS
)
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic clk_link_i,
  input wire logic [SAMPLE_W-1:0] lane0_samples_i,
  input wire logic [SAMPLE_W-1:0] lane1_samples_i,
  input wire logic [SAMPLE_W-1:0] lane2_samples_i,
  input wire logic key_ready_i,
  input wire logic [PIX_W-1:0] keystream_i,
  input wire logic out_ready_i,
  output logic [PIX_W-1:0] even_pixel_out_o,
  output logic [PIX_W-1:0] odd_pixel_out_o,
  output logic active_video_o,
  output logic hsync_o,
  output logic vsync_o,
  output logic [1:0] user_control_outputs_o,
  output logic pixel_valid_o,
  output logic keystream_step_o,
  output logic link_activity_flag_o,
  output logic overrun_o
);
  localparam int IDLE_W = $clog2(INACTIVE_PIXELS_P + 1);
  localparam logic [IDLE_W-1:0] IDLE_MAX = IDLE_W'(INACTIVE_PIXELS_P - 1);
  localparam logic [7:0] LOCK_LAST = 8'(LOCK_HITS_P - 1);
  localparam logic [7:0] UNLOCK_LAST = 8'(UNLOCK_MISSES_P - 1);
  localparam logic [3:0] TRANS_LAST = 4'(TRANS_FOR_ACTIVE - 1);

  if (LOCK_HITS_P < 2 || LOCK_HITS_P > 256 || UNLOCK_MISSES_P < 2 || UNLOCK_MISSES_P > 256
      || INACTIVE_PIXELS_P < 2) begin : g_bad_param
    $error("tmdsrx_top counts out of range");
  end

  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    logic act_meta;
    logic act_sync;
    logic [LANES-1:0][SAMPLE_W-1:0] prev;
    logic [LANES-1:0][CAND_W-1:0] cand;
    logic [LANES-1:0] locked;
    logic [LANES-1:0][7:0] run;
    logic [LANES-1:0][CHAR_W-1:0] chr;
    logic [LANES-1:0][CHAR_W-1:0] chr_d;
    logic [LANES-1:0] skew;
    logic overrun;
  } tmdsrx_link_s;

  typedef struct packed {
    logic ovr_meta;
    logic ovr_sync;
    logic [PIX_W-1:0] even_hold;
    logic odd_slot;
    logic [PIX_W-1:0] even_out;
    logic [PIX_W-1:0] odd_out;
    logic de_out;
    logic hs;
    logic vs;
    logic [1:0] uctl;
    logic valid;
    logic step;
    logic decrypt_enable_code;
    logic de_last;
    logic active;
    logic [3:0] trans_cnt;
    logic [IDLE_W-1:0] idle;
  } tmdsrx_sys_s;

  tmdsrx_link_s l, next_l;
  tmdsrx_sys_s s, next_s;
  logic [LANES-1:0][SAMPLE_W-1:0] samples;
  logic wr_valid, wr_ready, rd_valid;
  logic [WORD_W-1:0] wr_data, rd_data;

  assign samples = {lane2_samples_i, lane1_samples_i, lane0_samples_i};

  // Picks one bit per four samples, starting at a phase and bit offset candidate
  function automatic logic [CHAR_W-1:0] extract(input logic [2*SAMPLE_W-1:0] win, input logic [CAND_W-1:0] b);
    logic [CHAR_W-1:0] c;
    c = '0;
    for (int k = 0; k < CHAR_W; k++)
    begin
      c[k] = win[int'(b) + OSR * k]; // R1 R2
    end
    return c;
  endfunction

  // Returns {is_control, code}
  function automatic logic [2:0] ctrl_decode(input logic [CHAR_W-1:0] c);
    case (c)
      CTRL_CHAR_00: return 3'h4;
      CTRL_CHAR_01: return 3'h5;
      CTRL_CHAR_10: return 3'h6;
      CTRL_CHAR_11: return 3'h7;
      default: return 3'h0;
    endcase
  endfunction

  // Control flag alone; a select on a call result is not portable
  function automatic logic is_ctrl(input logic [CHAR_W-1:0] c);
    logic [2:0] v;
    v = ctrl_decode(c);
    return v[2];
  endfunction

  // Two-bit control code alone
  function automatic logic [1:0] ctrl_code(input logic [CHAR_W-1:0] c);
    logic [2:0] v;
    v = ctrl_decode(c);
    return v[1:0];
  endfunction

  // Undo the optional inversion, then the XOR or XNOR chain
  function automatic logic [DATA_W-1:0] pix_decode(input logic [CHAR_W-1:0] c);
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] q;
    d = c[INV_BIT] ? ~c[DATA_W-1:0] : c[DATA_W-1:0]; // R19
    q = '0;
    q[0] = d[0];
    for (int i = 1; i < DATA_W; i++)
    begin
      q[i] = c[XOR_BIT] ? (d[i] ^ d[i-1]) : ~(d[i] ^ d[i-1]); // R19
    end
    return q;
  endfunction

  // ************************************************************
  // Link domain: alignment, deskew, decode
  // ************************************************************
  always_comb
  begin
    logic [CHAR_W-1:0] raw;
    logic [LANES-1:0][CHAR_W-1:0] sel;
    logic [LANES-1:0] de_now;
    logic [LANES-1:0] de_prev;
    raw = '0;
    sel = '0;
    de_now = '0;
    de_prev = '0;
    next_l = l;
    next_l.rst_meta = rst_i;
    next_l.rst_sync = l.rst_meta;
    next_l.act_meta = s.active;
    next_l.act_sync = l.act_meta;
    for (int i = 0; i < LANES; i++)
    begin
      raw = extract({samples[i], l.prev[i]}, l.cand[i]);
      next_l.prev[i] = samples[i];
      next_l.chr[i] = raw;
      next_l.chr_d[i] = l.chr[i];
      de_now[i] = ~is_ctrl(l.chr[i]);
      de_prev[i] = ~is_ctrl(l.chr_d[i]);
      sel[i] = l.skew[i] ? l.chr_d[i] : l.chr[i];
      // Search walks all forty phase and offset candidates on blanking characters
      if (!l.locked[i])
      begin
        if (is_ctrl(raw))
        begin
          next_l.run[i] = l.run[i] + 8'h01;
          if (l.run[i] == LOCK_LAST)
          begin
            next_l.locked[i] = 1'b1; // R5
            next_l.run[i] = 8'h00;
          end
        end
        else
        begin
          next_l.cand[i] = (l.cand[i] == CAND_MAX) ? '0 : l.cand[i] + 6'h01; // R5
          next_l.run[i] = 8'h00;
        end
      end
      // Alignment held while active; only an idle link may drop it
      else if (is_ctrl(raw) || l.act_sync)
      begin
        next_l.run[i] = 8'h00; // R4
      end
      else if (l.run[i] == UNLOCK_LAST)
      begin
        next_l.locked[i] = 1'b0;
        next_l.run[i] = 8'h00;
      end
      else
      begin
        next_l.run[i] = l.run[i] + 8'h01;
      end
    end
    // Early lanes get one pixel of delay at the start of active video
    if (&l.locked && ~|de_prev && |de_now)
    begin
      next_l.skew = (&de_now) ? '0 : de_now; // R3
    end
    wr_valid = &l.locked;
    if (is_ctrl(sel[0]))
    begin
      wr_data = {1'b0, CTRL_PAD_W'(0), ctrl_code(sel[2]), ctrl_code(sel[1]), ctrl_code(sel[0])}; // R8 R10
    end
    else
    begin
      wr_data = {1'b1, pix_decode(sel[2]), pix_decode(sel[1]), pix_decode(sel[0])}; // R8 R9
    end
    if (wr_valid && !wr_ready)
    begin
      next_l.overrun = 1'b1;
    end
    if (l.rst_sync)
    begin
      next_l.cand = '0;
      next_l.locked = '0;
      next_l.run = '0;
      next_l.skew = '0;
      next_l.overrun = 1'b0;
    end
  end

  always_ff @(posedge clk_link_i)
  begin
    l <= next_l;
  end

  // Four-word crossing; out_ready_i low stalls the drain and makes it fill
  tmdsrx_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .wr_clk_i(clk_link_i),
    .wr_rst_i(l.rst_sync),
    .wr_valid_i(wr_valid),
    .wr_ready_o(wr_ready),
    .wr_data_i(wr_data),
    .rd_clk_i(clk_sys_i),
    .rd_rst_i(rst_i),
    .rd_valid_o(rd_valid),
    .rd_ready_i(out_ready_i),
    .rd_data_o(rd_data)
  );

  // ************************************************************
  // System domain: decrypt, pair, activity
  // ************************************************************
  logic pop, trans, decrypt_on;
  logic [PIX_W-1:0] pix;

  always_comb
  begin
    next_s = s;
    next_s.valid = 1'b0;
    next_s.step = 1'b0;
    next_s.ovr_meta = l.overrun;
    next_s.ovr_sync = s.ovr_meta;
    pop = rd_valid && out_ready_i;
    decrypt_on = s.decrypt_enable_code && key_ready_i; // R12 R14
    pix = rd_data[PIX_W-1:0] ^ (decrypt_on ? keystream_i : '0); // R13
    trans = pop && (rd_data[W_DE] != s.de_last); // R15
    if (pop)
    begin
      next_s.de_last = rd_data[W_DE];
      if (rd_data[W_DE])
      begin
        next_s.step = decrypt_on;
        // Pairs leave together; a lone last pixel of a line is dropped
        if (!s.odd_slot)
        begin
          next_s.even_hold = pix;
          next_s.odd_slot = 1'b1;
        end
        else
        begin
          next_s.even_out = s.even_hold; // R9
          next_s.odd_out = pix; // R9
          next_s.de_out = 1'b1;
          next_s.valid = 1'b1;
          next_s.odd_slot = 1'b0;
        end
      end
      else
      begin
        next_s.de_out = 1'b0;
        next_s.hs = rd_data[HS_BIT]; // R10
        next_s.vs = rd_data[VS_BIT]; // R10
        next_s.uctl = {rd_data[USER2_BIT], rd_data[USER1_BIT]}; // R11
        next_s.decrypt_enable_code = rd_data[DECRYPT_EN_BIT]; // R12
        next_s.valid = 1'b1;
        next_s.odd_slot = 1'b0;
      end
    end
    // An empty FIFO also ages the link, so a dead cable still times out
    if (trans)
    begin
      next_s.idle = '0; // R16
      if (!s.active)
      begin
        if (s.trans_cnt == TRANS_LAST)
        begin
          next_s.active = 1'b1; // R18
          next_s.trans_cnt = 4'h0;
        end
        else
        begin
          next_s.trans_cnt = s.trans_cnt + 4'h1; // R15
        end
      end
    end
    else if (pop || !rd_valid)
    begin
      if (s.idle == IDLE_MAX)
      begin
        next_s.active = 1'b0; // R17
        next_s.trans_cnt = 4'h0;
      end
      else
      begin
        next_s.idle = s.idle + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs straight from flops
  assign even_pixel_out_o = s.even_out;
  assign odd_pixel_out_o = s.odd_out;
  assign active_video_o = s.de_out;
  assign hsync_o = s.hs;
  assign vsync_o = s.vs;
  assign user_control_outputs_o = s.uctl;
  assign pixel_valid_o = s.valid;
  assign keystream_step_o = s.step;
  assign link_activity_flag_o = s.active;
  assign overrun_o = s.ovr_sync;

  // ************************************************************
  // Checks
  // ************************************************************
  a_lock_on_control: assert property (@(posedge clk_link_i) disable iff (l.rst_sync) // R5
    $rose(l.locked[0]) |-> is_ctrl(l.chr[0]))
    else $error("lane locked without control character");
  a_lock_holds: assert property (@(posedge clk_link_i) disable iff (l.rst_sync) // R4
    l.locked[1] && l.act_sync |=> l.locked[1])
    else $error("lane lost alignment while link active");
  a_de_class: assert property (@(posedge clk_link_i) disable iff (l.rst_sync) // R8
    wr_valid && is_ctrl(l.skew[0] ? l.chr_d[0] : l.chr[0]) |-> !wr_data[W_DE])
    else $error("control character classed as pixel");
  a_sync_map: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R10
    pop && !rd_data[W_DE] |=> hsync_o == $past(rd_data[HS_BIT]) && vsync_o == $past(rd_data[VS_BIT]))
    else $error("sync outputs not taken from lane 0");
  a_user_ctl: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R11
    pop && !rd_data[W_DE] |=> user_control_outputs_o == {$past(rd_data[USER2_BIT]), $past(rd_data[USER1_BIT])})
    else $error("user control outputs wrong");
  a_pixel_pair: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R9 R13
    pop && rd_data[W_DE] && s.odd_slot |=> pixel_valid_o && odd_pixel_out_o == $past(pix)
      && even_pixel_out_o == $past(s.even_hold))
    else $error("pixel pair not presented");
  a_decrypt_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R12 R14
    pop && rd_data[W_DE] && !(s.decrypt_enable_code && key_ready_i) |-> pix == rd_data[PIX_W-1:0])
    else $error("pixel altered with decryption off");
  a_trans_count: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R15
    trans && !s.active && s.trans_cnt < TRANS_LAST |=> s.trans_cnt == $past(s.trans_cnt) + 4'h1)
    else $error("transition not counted");
  a_active_rise: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R18
    $rose(link_activity_flag_o) |-> $past(trans) && $past(s.trans_cnt) == TRANS_LAST)
    else $error("activity rose without eighth transition");
  a_inactive_fall: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R16 R17
    $fell(link_activity_flag_o) |-> $past(s.idle) == IDLE_MAX && !$past(trans))
    else $error("activity fell before timeout");
  c_all_locked: cover property (@(posedge clk_link_i) disable iff (l.rst_sync) $rose(&l.locked));
  c_skew_used: cover property (@(posedge clk_link_i) disable iff (l.rst_sync) |l.skew);
  c_link_up: cover property (@(posedge clk_sys_i) disable iff (rst_i) $rose(link_activity_flag_o));
  c_decrypted: cover property (@(posedge clk_sys_i) disable iff (rst_i) keystream_step_o);
endmodule // tmdsrx_top
`default_nettype wire

//--- sim/tmdsrx_tx_model.sv
// Behavioural far-end transmitter: encodes pixels or control codes into 4x oversampled lanes.
// Assumes its inputs change away from clk_link_i rising edges; lane 2 may lag one character.
`timescale 1ns/1ps
`default_nettype none
module tmdsrx_tx_model
  import tmdsrx_pkg::*;
(
  input wire logic clk_link_i,
  input wire logic de_i,
  input wire logic [PIX_W-1:0] pix_i,
  input wire logic [5:0] codes_i,
  input wire logic skew_i,
  output logic [SAMPLE_W-1:0] lane0_o,
  output logic [SAMPLE_W-1:0] lane1_o,
  output logic [SAMPLE_W-1:0] lane2_o
);
  localparam logic [CHAR_W-1:0] CTRL_TBL [4] = '{CTRL_CHAR_00, CTRL_CHAR_01, CTRL_CHAR_10, CTRL_CHAR_11};
  int disp [LANES];
  logic [CHAR_W-1:0] chr [LANES];
  logic [SAMPLE_W-1:0] lane2_now;
  logic [SAMPLE_W-1:0] lane2_d;

  // ************************************************************
  // Encoder and serialiser
  // ************************************************************
  // Two candidate characters, pick by running disparity
  function automatic logic [CHAR_W-1:0] enc(input logic [7:0] d, input int cnt, output int nc);
    logic [8:0] q;
    int n1;
    logic xn;
    n1 = $countones(d);
    xn = (n1 > 4) || (n1 == 4 && !d[0]);
    q[0] = d[0];
    for (int i = 1; i < 8; i++) q[i] = xn ? ~(q[i-1] ^ d[i]) : (q[i-1] ^ d[i]);
    q[8] = !xn;
    n1 = $countones(q[7:0]);
    if (cnt == 0 || n1 == 4)
    begin
      nc = q[8] ? cnt + 2 * n1 - 8 : cnt + 8 - 2 * n1;
      return {~q[8], q[8], q[8] ? q[7:0] : ~q[7:0]};
    end
    if ((cnt > 0 && n1 > 4) || (cnt < 0 && n1 < 4))
    begin
      nc = cnt + 2 * int'(q[8]) + 8 - 2 * n1;
      return {1'b1, q[8], ~q[7:0]};
    end
    nc = cnt - 2 * int'(!q[8]) + 2 * n1 - 8;
    return {1'b0, q[8], q[7:0]};
  endfunction

  // Each bit repeated on four phases, first bit lowest
  function automatic logic [SAMPLE_W-1:0] spread(input logic [CHAR_W-1:0] c);
    for (int k = 0; k < SAMPLE_W; k++) spread[k] = c[k / OSR];
  endfunction

  // One character per lane per link clock; skew delays lane 2 by a pixel
  always @(posedge clk_link_i)
  begin
    for (int l = 0; l < LANES; l++)
    begin
      if (de_i) chr[l] = enc(pix_i[8*l +: 8], disp[l], disp[l]);
      else
      begin
        chr[l] = CTRL_TBL[codes_i[2*l +: 2]];
        disp[l] = 0;
      end
    end
    lane2_now = spread(chr[2]);
    lane0_o <= spread(chr[0]);
    lane1_o <= spread(chr[1]);
    lane2_o <= skew_i ? lane2_d : lane2_now;
    lane2_d <= lane2_now;
  end
endmodule // tmdsrx_tx_model
`default_nettype wire

//--- sim/tmdsrx_tb.sv
// Self-checking bench for the three-lane receiver: table of runs, then inactivity, reset, skew and stall.
// Assumes tmdsrx_pkg and tmdsrx_top are compiled first; the link clock outruns the drain.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tmdsrx_pkg::*;
  typedef struct {logic de; logic key; logic [23:0] val; logic [23:0] exp; logic act; logic step;} tmdsrx_row_s;
  logic clk_sys, rst, clk_link, key_ready, out_ready, de, skew;
  logic [23:0] keystream, pix, even_pix, odd_pix;
  logic [5:0] codes;
  logic active, hs, vs, pv, kstep, act_flag, overrun;
  logic [1:0] user;
  logic [SAMPLE_W-1:0] l0, l1, l2;
  int err_total, checks_done, steps, cycles;
  tmdsrx_row_s rows [10];

  tmdsrx_top #(.LOCK_HITS_P(4), .UNLOCK_MISSES_P(200), .INACTIVE_PIXELS_P(64)) tmdsrx_top_inst (
    .clk_sys_i(clk_sys), .rst_i(rst), .clk_link_i(clk_link), .lane0_samples_i(l0), .lane1_samples_i(l1),
    .lane2_samples_i(l2), .key_ready_i(key_ready), .keystream_i(keystream), .out_ready_i(out_ready),
    .even_pixel_out_o(even_pix), .odd_pixel_out_o(odd_pix), .active_video_o(active), .hsync_o(hs),
    .vsync_o(vs), .user_control_outputs_o(user), .pixel_valid_o(pv), .keystream_step_o(kstep),
    .link_activity_flag_o(act_flag), .overrun_o(overrun));
  tmdsrx_tx_model tmdsrx_tx_model_inst (.clk_link_i(clk_link), .de_i(de), .pix_i(pix), .codes_i(codes),
    .skew_i(skew), .lane0_o(l0), .lane1_o(l1), .lane2_o(l2));

  // ************************************************************
  // Clocks, timeout and shared tasks
  // ************************************************************
  // Link edges at 9+12k ns never meet system edges
  initial
  begin
    clk_sys = 0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    clk_link = 0;
    #3;
    forever #6 clk_link = ~clk_link;
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Step pulses counted away from the edge that launches them
  always @(negedge clk_sys)
  begin
    if (kstep === 1'b1) steps++;
  end

  // Whole run is about 570 cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: timeout", $time);
      test_done();
    end
  end

  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // Bounded wait for an update pulse of the wanted kind
  task automatic wait_pv(input logic want);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (!(pv === 1'b1 && active === want) && n < 60)
    begin
      n++;
      @(negedge clk_sys);
    end
    check(n < 60, "no output update");
  endtask

  task automatic run_row(input tmdsrx_row_s r);
    de = r.de;
    key_ready = r.key;
    if (r.de) pix = r.val;
    else codes = r.val[5:0];
    repeat (12) @(negedge clk_sys);
    steps = 0;
    wait_pv(r.de);
    if (r.de) check(even_pix === r.exp && odd_pix === r.exp, "pixel pair");
    else check({user, vs, hs} === r.exp[3:0], "control outputs");
    check(act_flag === r.act, "link activity");
    repeat (4) @(negedge clk_sys);
    check((steps > 0) === r.step, "keystream steps");
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    rst = 1;
    key_ready = 0;
    keystream = 24'h3C96F0;
    out_ready = 1;
    de = 0;
    pix = 24'h0;
    codes = 6'h00;
    skew = 0;
    // Control rows: val {lane2,lane1,lane0 codes}, exp {user,vsync,hsync}
    rows = '{'{0, 0, 24'h00, 24'h0, 0, 0}, '{1, 0, 24'hFF0080, 24'hFF0080, 0, 0},
      '{0, 0, 24'h19, 24'hD, 0, 0}, '{1, 0, 24'h123456, 24'h123456, 0, 0},
      '{0, 0, 24'h26, 24'h2, 0, 0}, '{1, 0, 24'hA5C3E1, 24'hA5C3E1, 0, 0},
      '{0, 1, 24'h3F, 24'hF, 0, 0}, '{1, 1, 24'h00FF7E, 24'h3C698E, 0, 1},
      '{0, 1, 24'h00, 24'h0, 1, 0}, '{1, 1, 24'h5A5A5A, 24'h5A5A5A, 1, 0}};
    repeat (6) @(negedge clk_sys);
    rst = 0;
    repeat (100) @(negedge clk_sys);
    for (int i = 0; i < 10; i++)
    begin
      run_row(rows[i]);
      $display("row %0d done", i);
    end
    // Quiet blanking: flag holds, then drops near 64 pops
    de = 0;
    repeat (30) @(negedge clk_sys);
    check(act_flag === 1'b1, "activity held");
    repeat (100) @(negedge clk_sys);
    check(act_flag === 1'b0, "activity timeout");
    $display("inactivity test done");
    // Second reset in mid-run clears every output
    rst = 1;
    repeat (2) @(negedge clk_sys);
    check({even_pix, odd_pix, active, hs, vs, user, pv, kstep, act_flag, overrun} === '0, "reset outputs");
    repeat (4) @(negedge clk_sys);
    skew = 1;
    rst = 0;
    repeat (100) @(negedge clk_sys);
    run_row(rows[2]);
    run_row(rows[3]);
    check(overrun === 1'b1, "overrun flag");
    $display("skew test done");
    // Consumer stall freezes the outputs
    out_ready = 0;
    repeat (3) @(negedge clk_sys);
    repeat (10)
    begin
      @(negedge clk_sys);
      check(pv === 1'b0, "stalled update");
    end
    out_ready = 1;
    wait_pv(1'b1);
    check(even_pix === 24'h123456, "pixel after stall");
    $display("stall test done");
    test_done();
  end
endmodule // testbench
`default_nettype wire
